// file: design/csm_cipher_decode.sv
// Maps a raw cipher field code to a sub-state; reserved codes keep the old one.
module csm_cipher_decode (
  input wire logic [3:0] code,
  input wire csm_pkg::csm_cipher_state_t current,
  output csm_pkg::csm_cipher_state_t next_sub
);

  // Reserved codes start nothing, so the machine simply stays where it is.
  always_comb
  begin
    case (code)
      4'h1: next_sub = csm_pkg::CIP_IDLE;
      4'h2: next_sub = csm_pkg::CIP_ENCRYPT;
      4'h3: next_sub = csm_pkg::CIP_DECRYPT;
      4'h4: next_sub = csm_pkg::CIP_ENC_WRITE;
      4'h5: next_sub = csm_pkg::CIP_ENC_READ;
      4'h6: next_sub = csm_pkg::CIP_KEY_LOAD;
      4'h7: next_sub = csm_pkg::CIP_SEED_CREATE;
      4'h8: next_sub = csm_pkg::CIP_HASHED_SEED_READ;
      4'h9: next_sub = csm_pkg::CIP_DIRECT_SEED_READ;
      4'hA: next_sub = csm_pkg::CIP_HASH_AUTH;
      4'hB: next_sub = csm_pkg::CIP_LOCK;
      4'hF: next_sub = csm_pkg::CIP_STOP;
      default: next_sub = current;
    endcase
  end

endmodule

// file: design/csm_field_reg.sv
// A byte register whose low field is writable; upper bits read as zero.
module csm_field_reg #(
  parameter int WIDTH = 3,
  parameter logic [16:0] ADDR = csm_pkg::ADDR_SPI
) (
  input wire logic clk,
  input wire logic rst,
  input wire csm_pkg::csm_bus_req_t req,
  output logic [WIDTH-1:0] field,
  output logic written
);

  if (WIDTH < 1 || WIDTH > 8)
  begin : g_bad_width
    $error("csm_field_reg: WIDTH must be 1 to 8");
  end

  typedef struct packed
  {
    logic [WIDTH-1:0] field;
    logic written;
  } csm_freg_state_t;

  csm_freg_state_t state;
  csm_freg_state_t next_state;

  // Capture only the implemented bits; the written pulse lets decoders act once.
  always_comb
  begin
    next_state = state;
    next_state.written = 1'b0;
    if (req.wr && req.addr == ADDR)
    begin
      next_state.field = req.wdata[WIDTH-1:0];
      next_state.written = 1'b1;
    end
  end

  // Every field resets to zero.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign field = state.field;
  assign written = state.written;

endmodule

// file: design/csm_pkg.sv
// What this block does
// - Writing 4 to the SPI sub-state field enters the SPI hash sub-state.
// - Other values in the SPI sub-state field start no specific action.
// - Writing 2 to the random field selects host-driven random generation.
// - Writing 4 to the random field hands random generation to the cipher.
// - Writing 1 to the cipher field returns the cipher machine to idle.
// - Cipher codes 2 and 3 select block encrypt and block decrypt.
// - Cipher codes 4 and 5 select encrypted write and encrypted read.
// - Cipher code 6 selects key load into the cipher engine.
// - Cipher code 7 selects random seed creation.
// - Cipher field offers hashed and direct seed read, hash auth and lock.
// - Cipher code C is reserved and starts no operation.
// - Cipher code F moves the cipher machine to its stop sub-state.
package csm_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [16:0] ADDR_RSVD_A = 17'h10605;
  localparam logic [16:0] ADDR_SPI = 17'h10606;
  localparam logic [16:0] ADDR_RSVD_B = 17'h10607;
  localparam logic [16:0] ADDR_RND = 17'h10608;
  localparam logic [16:0] ADDR_CIP = 17'h10609;
  localparam int SPI_FIELD_MSB = 2;
  localparam int RND_FIELD_MSB = 2;
  localparam int CIP_FIELD_MSB = 3;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ==========================================================================
  // Field codes
  // ==========================================================================
  localparam logic [2:0] SPI_CODE_HASH = 3'h4;
  localparam logic [2:0] SPI_CODE_LEAVE = 3'h1;
  localparam logic [2:0] RND_CODE_HOST = 3'h2;
  localparam logic [2:0] RND_CODE_CIPHER = 3'h4;

  typedef enum logic [3:0]
  {
    CIP_NONE = 4'h0,
    CIP_IDLE = 4'h1,
    CIP_ENCRYPT = 4'h2,
    CIP_DECRYPT = 4'h3,
    CIP_ENC_WRITE = 4'h4,
    CIP_ENC_READ = 4'h5,
    CIP_KEY_LOAD = 4'h6,
    CIP_SEED_CREATE = 4'h7,
    CIP_HASHED_SEED_READ = 4'h8,
    CIP_DIRECT_SEED_READ = 4'h9,
    CIP_HASH_AUTH = 4'hA,
    CIP_LOCK = 4'hB,
    CIP_STOP = 4'hF
  } csm_cipher_state_t;

  // Host write and read strobes with address and data.
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [16:0] addr;
    logic [7:0] wdata;
  } csm_bus_req_t;

  // Decoded sub-state selections presented to the functional engines.
  typedef struct packed
  {
    logic spi_hash_substate;
    logic host_driven_random_gen;
    logic cipher_driven_random_gen;
    csm_cipher_state_t cipher_state;
  } csm_sel_t;

endpackage

// file: design/csm_substate_regs.sv
// Sub-state selection registers for SPI hash, random and cipher sub-states.
module csm_substate_regs (
  input wire logic clk,
  input wire logic rst,
  input wire csm_pkg::csm_bus_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output csm_pkg::csm_sel_t sel
);

  // ==========================================================================
  // Field registers
  // ==========================================================================
  logic [2:0] spi_field;
  logic [2:0] rnd_field;
  logic [3:0] cip_field;
  logic cip_written;

  csm_field_reg #(
    .WIDTH(csm_pkg::SPI_FIELD_MSB + 1),
    .ADDR(csm_pkg::ADDR_SPI)
  ) u_spi (
    .clk(clk),
    .rst(rst),
    .req(req),
    .field(spi_field),
    .written()
  );

  csm_field_reg #(
    .WIDTH(csm_pkg::RND_FIELD_MSB + 1),
    .ADDR(csm_pkg::ADDR_RND)
  ) u_rnd (
    .clk(clk),
    .rst(rst),
    .req(req),
    .field(rnd_field),
    .written()
  );

  csm_field_reg #(
    .WIDTH(csm_pkg::CIP_FIELD_MSB + 1),
    .ADDR(csm_pkg::ADDR_CIP)
  ) u_cip (
    .clk(clk),
    .rst(rst),
    .req(req),
    .field(cip_field),
    .written(cip_written)
  );

  // ==========================================================================
  // Cipher sub-state machine
  // ==========================================================================
  typedef struct packed
  {
    csm_pkg::csm_cipher_state_t cipher_state;
    logic [7:0] rdata;
    logic rvalid;
  } csm_top_state_t;

  csm_top_state_t state;
  csm_top_state_t next_state;
  csm_pkg::csm_cipher_state_t decoded;

  csm_cipher_decode u_dec (
    .code(cip_field),
    .current(state.cipher_state),
    .next_sub(decoded)
  );

  // The machine follows a write only once, one cycle after the field updates,
  // so a reserved write leaves the previous sub-state untouched.
  always_comb
  begin
    next_state = state;
    next_state.rvalid = 1'b0;
    if (cip_written)
    begin
      next_state.cipher_state = decoded;
    end
    if (req.rd)
    begin
      next_state.rvalid = 1'b1;
      if (req.addr == csm_pkg::ADDR_SPI)
      begin
        next_state.rdata = {5'h00, spi_field};
      end
      else if (req.addr == csm_pkg::ADDR_RND)
      begin
        next_state.rdata = {5'h00, rnd_field};
      end
      else if (req.addr == csm_pkg::ADDR_CIP)
      begin
        next_state.rdata = {4'h0, cip_field};
      end
      else
      begin
        next_state.rdata = 8'h00; // Reserved and unmapped bytes read zero.
      end
    end
  end

  // Synchronous reset puts every sub-state at zero, which selects nothing.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= '{cipher_state: csm_pkg::CIP_NONE, rdata: csm_pkg::RESET_VALUE, rvalid: 1'b0};
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Only exact codes select; leaving hash needs no specific code, any code other than 4 drops it.
  assign sel.spi_hash_substate = (spi_field == csm_pkg::SPI_CODE_HASH);
  assign sel.host_driven_random_gen = (rnd_field == csm_pkg::RND_CODE_HOST);
  assign sel.cipher_driven_random_gen = (rnd_field == csm_pkg::RND_CODE_CIPHER);
  assign sel.cipher_state = state.cipher_state;
  assign rdata = state.rdata;
  assign rvalid = state.rvalid;

endmodule

// file: verif/csm_host_model.sv
module csm_host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output csm_pkg::csm_bus_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [16:0] MAIN_ADDR = 17'h10604;
  localparam logic [16:0] COMMIT_ADDR = 17'h10601;
  // ==========================================
  // Host transfers
  // ==========================================
  // Idle bus at time zero.
  initial req = '0;
  // Optional write, then a read of the same byte in the very next cycle.
  // Released lines show inverted values so no stale address looks valid.
  task automatic xfer(input logic w, input logic [16:0] a, input logic [7:0] d, output logic [7:0] q);
    if (w)
    begin
      @(negedge clk);
      req = '{1'b1, 1'b0, a, d};
    end
    @(negedge clk);
    req = '{1'b0, 1'b1, a, ~d};
    @(negedge clk);
    req = '{1'b0, 1'b0, ~a, ~d};
    q = rvalid ? rdata : 8'hEE;
  endtask
endmodule

// file: verif/csm_substate_regs_properties.sv
module csm_substate_checker (
  input wire logic clk,
  input wire logic rst,
  input wire csm_pkg::csm_bus_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire csm_pkg::csm_sel_t sel
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Write decodes
  // ==========================================
  // Cipher codes 0 and C to E are refused, so they must not move the state.
  wire w_spi = req.wr && req.addr == csm_pkg::ADDR_SPI;
  wire w_rnd = req.wr && req.addr == csm_pkg::ADDR_RND;
  wire w_cip = req.wr && req.addr == csm_pkg::ADDR_CIP;
  wire c_bad = req.wdata[3:0] == 4'h0 || req.wdata[3:0] > 4'hB && req.wdata[3:0] != 4'hF;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================
  // Properties
  // ==========================================
  // A lone cipher write, so the two-edge latency is not blurred by a follower.
  sequence s_cip_ok;
    w_cip && !c_bad ##1 !w_cip;
  endsequence
  sequence s_cip_bad;
    !w_cip ##1 w_cip && c_bad ##1 !w_cip;
  endsequence
  chk_spi_hash_on: assert property (w_spi && req.wdata[2:0] == 3'h4 |=> sel.spi_hash_substate)
    else $error("spi hash not entered");
  chk_spi_hash_off: assert property (w_spi && req.wdata[2:0] != 3'h4 |=> !sel.spi_hash_substate)
    else $error("spi hash not dropped");
  chk_rnd_host_sel: assert property (w_rnd |=> sel.host_driven_random_gen == ($past(req.wdata[2:0]) == 3'h2))
    else $error("host random select wrong");
  chk_rnd_cipher_sel: assert property (w_rnd |=> sel.cipher_driven_random_gen == ($past(req.wdata[2:0]) == 3'h4))
    else $error("cipher random select wrong");
  chk_cip_decode: assert property (s_cip_ok |=> sel.cipher_state == $past(req.wdata[3:0], 2))
    else $error("cipher state decode wrong");
  chk_cip_reserved: assert property (s_cip_bad |=> $stable(sel.cipher_state))
    else $error("reserved cipher code moved state");
  chk_read_back: assert property (w_spi ##1 req.rd && req.addr == csm_pkg::ADDR_SPI
    |=> rvalid && rdata == {5'h00, $past(req.wdata[2:0], 2)})
    else $error("read after write stale");
  chk_rsvd_zero: assert property (req.rd && (req.addr == csm_pkg::ADDR_RSVD_A || req.addr == csm_pkg::ADDR_RSVD_B)
    |=> rvalid && rdata == 8'h00)
    else $error("reserved byte not zero");
  chk_read_pulse: assert property (!req.rd |=> !rvalid)
    else $error("read valid without read");
endmodule
bind csm_substate_regs csm_substate_checker chk (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
  .sel(sel));

// file: verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  int n_errors = 0;
  int n_tests = 0;
  logic [7:0] q;
  logic [3:0] codes [12] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hF, 4'h1};
  logic [3:0] bad [4] = '{4'hC, 4'hD, 4'hE, 4'h0};
  csm_pkg::csm_bus_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  csm_pkg::csm_sel_t sel;
  // ==========================================
  // Harness
  // ==========================================
  // Free-running 200 MHz clock.
  always #2.5 clk = ~clk;
  csm_substate_regs dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .sel(sel));
  csm_host_model host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic put(input logic [16:0] a, input logic [7:0] d, input logic [7:0] e);
    host.xfer(1'b1, a, d, q);
    check("readback", q, e);
  endtask
  task automatic sel_is(input logic [6:0] e);
    check("sel", {1'b0, sel}, {1'b0, e});
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && n_tests > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Tests
  // ==========================================
  // A hang costs a mismatch; the run needs about 0.7 us.
  initial
  begin
    #20000;
    n_errors++;
    give_verdict();
  end
  // Main sequence of host calls.
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    sel_is(7'h00);
    for (int i = 5; i < 10; i++)
    begin
      host.xfer(1'b0, 17'h10600 + 17'(i), 8'h00, q);
      check("reset value", q, 8'h00);
    end
    put(csm_pkg::ADDR_SPI, 8'hFC, 8'h04);
    sel_is(7'h40);
    put(csm_pkg::ADDR_SPI, 8'h03, 8'h03);
    sel_is(7'h00);
    put(csm_pkg::ADDR_SPI, 8'h04, 8'h04);
    sel_is(7'h40);
    put(csm_pkg::ADDR_SPI, 8'h01, 8'h01);
    sel_is(7'h00);
    put(csm_pkg::ADDR_RND, 8'hFA, 8'h02);
    sel_is(7'h20);
    put(csm_pkg::ADDR_RND, 8'h04, 8'h04);
    sel_is(7'h10);
    put(csm_pkg::ADDR_RSVD_A, 8'hFF, 8'h00);
    put(csm_pkg::ADDR_RSVD_B, 8'hFF, 8'h00);
    put(17'h10610, 8'hFF, 8'h00);
    put(host.MAIN_ADDR, 8'h09, 8'h00);
    foreach (codes[i])
    begin
      put(csm_pkg::ADDR_CIP, {4'hF, codes[i]}, {4'h0, codes[i]});
      sel_is({3'h1, codes[i]});
      put(csm_pkg::ADDR_CIP, 8'h01, 8'h01);
      sel_is(7'h11);
    end
    put(csm_pkg::ADDR_CIP, 8'h0B, 8'h0B);
    foreach (bad[i])
    begin
      put(csm_pkg::ADDR_CIP, {4'h0, bad[i]}, {4'h0, bad[i]});
      sel_is(7'h1B);
    end
    put(host.MAIN_ADDR, 8'h01, 8'h00);
    put(host.COMMIT_ADDR, 8'h00, 8'h00);
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    sel_is(7'h00);
    // The random field held 4 before this reset, so a zero here proves the clear.
    host.xfer(1'b0, csm_pkg::ADDR_RND, 8'h00, q);
    check("reset value", q, 8'h00);
    give_verdict();
  end
endmodule
